/* hdl/tddseq_pkg.sv */
package tddseq_pkg;

   // Channel layout: two transmit channels, then two receive channels
   localparam int unsigned NUM_CHAN      = 4;
   localparam int unsigned NUM_TX        = 2;
   localparam int unsigned NUM_PARAM     = 5;
   localparam int unsigned ADDR_W        = 8;
   localparam int unsigned DATA_W        = 32;

   // Clock and timing
   localparam int unsigned CLK_MHZ                = 250;
   localparam int unsigned PLAIN_SETUP_US         = 8;
   localparam int unsigned RETUNE_SETUP_US        = 758;
   localparam int unsigned PLAIN_SETUP_CYCLES     = PLAIN_SETUP_US * CLK_MHZ;
   localparam int unsigned RETUNE_SETUP_CYCLES    = RETUNE_SETUP_US * CLK_MHZ;
   localparam int unsigned SWITCH_MARGIN_CYCLES   = 16;
   localparam int unsigned CAL_CYCLES             = 64;
   localparam int unsigned INTERNAL_PATH_CYCLES   = 100;

   // Global registers (byte addresses)
   localparam logic [7:0] CTRL_ADDR        = 8'h00;
   localparam logic [7:0] STATUS_ADDR      = 8'h04;
   localparam logic [7:0] SETUP_TIME_ADDR  = 8'h08;
   localparam logic [7:0] PATH_TIME_ADDR   = 8'h0C;

   // Per-channel block: base 0x20, stride 0x20, one word per delay
   localparam logic [2:0] CHAN_BLOCK_FIRST = 3'h1;
   localparam int unsigned PRM_POWER_UP    = 0;  // rise_to_power_up_delay, +0x00
   localparam int unsigned PRM_SWITCH      = 1;  // rise_to_switch_delay, +0x04
   localparam int unsigned PRM_GUARD       = 2;  // guard_interval_delay, +0x08
   localparam int unsigned PRM_IF_OFF      = 3;  // fall_to_interface_off_delay, +0x0C
   localparam int unsigned PRM_POWER_DOWN  = 4;  // fall_to_power_down_delay, +0x10

   // CTRL fields
   localparam int unsigned CTRL_EXT_EN_LSB = 0;  // [3:0] external switch/amplifier control
   localparam int unsigned CTRL_RETUNE_BIT = 8;  // synthesizer retune at frame boundary

   // STATUS fields
   localparam int unsigned STAT_EN_LSB     = 0;
   localparam int unsigned STAT_PWR_LSB    = 4;
   localparam int unsigned STAT_SW_LSB     = 8;
   localparam int unsigned STAT_IF_LSB     = 12;
   localparam int unsigned STAT_CAL_BIT    = 16;

   localparam logic [1:0] RESP_OKAY        = 2'h0;
   localparam logic [1:0] RESP_SLVERR      = 2'h2;
   localparam logic [31:0] CNT_MAX         = 32'hFFFFFFFF;
   localparam logic [31:0] PARAM_RESET     = 32'h00000000;

endpackage // tddseq_pkg

/* hdl/tddseq_top.sv */
//Contract
//- Transmit switch goes to transmit after the rise-to-switch delay from enable rise.
//- Receive amplifier powers up after the rise-to-switch delay from enable rise.
//- Front end powers up after rise-to-power-up delay; zero means at once.
//- Receive data keeps passing for the interface-off delay after enable falls.
//- Transmit interface stays active for the interface-off delay after enable falls.
//- Receive power-down delay is forced to zero; amplifier drops with enable.
//- Transmit front end and switch return after power-down delay from enable fall.
//- Reported setup time is 8 us, or 758 us with a retune.
//- Any programmed delay value is accepted with no clamping.
//- With zero switch delay, switching waits for setup plus a margin.
//- Long power-up delay postpones switching until analog setup has finished.
//- Internal path transit time is measured by calibration after reset; the code loads the fixed INTERNAL_PATH_CYCLES when the 64-cycle window ends.
//- Transmit enable sequences interface, analog blocks and owned antenna switch.
//- All four channels sequence independently with their own resources.
//
// Added by the designer: the address map and the AXI4-Lite register port.
module tddseq_top #(
   parameter int unsigned RETUNE_SETUP_CYCLES  = tddseq_pkg::RETUNE_SETUP_CYCLES,
   parameter int unsigned INTERNAL_PATH_CYCLES = tddseq_pkg::INTERNAL_PATH_CYCLES
) (
   input  wire logic        aclk,              // 250 MHz clock
   input  wire logic        aresetn,           // Synchronous reset, low
   input  wire logic [3:0]  chan_enable,       // Enables: tx1, tx2, rx1, rx2
   output logic      [3:0]  front_end_power,   // Analog front end powered
   output logic      [3:0]  ext_switch_on,     // Antenna to tx / external amplifier on
   output logic      [3:0]  interface_active,  // Data interface passing data
   input  wire logic [7:0]  s_axi_awaddr,      // Write address
   input  wire logic [2:0]  s_axi_awprot,      // Write protection, unused
   input  wire logic        s_axi_awvalid,     // Write address valid
   output logic             s_axi_awready,     // Write address ready
   input  wire logic [31:0] s_axi_wdata,       // Write data
   input  wire logic [3:0]  s_axi_wstrb,       // Write byte strobes
   input  wire logic        s_axi_wvalid,      // Write data valid
   output logic             s_axi_wready,      // Write data ready
   output logic      [1:0]  s_axi_bresp,       // Write response
   output logic             s_axi_bvalid,      // Write response valid
   input  wire logic        s_axi_bready,      // Write response ready
   input  wire logic [7:0]  s_axi_araddr,      // Read address
   input  wire logic [2:0]  s_axi_arprot,      // Read protection, unused
   input  wire logic        s_axi_arvalid,     // Read address valid
   output logic             s_axi_arready,     // Read address ready
   output logic      [31:0] s_axi_rdata,       // Read data
   output logic      [1:0]  s_axi_rresp,       // Read response
   output logic             s_axi_rvalid,      // Read data valid
   input  wire logic        s_axi_rready       // Read data ready
);

   typedef struct packed {
      logic [3:0][4:0][31:0] prm;
      logic [3:0]            ext_en;
      logic                  retune;
      logic [3:0]            en_d;
      logic [3:0]            on_phase;
      logic [3:0][31:0]      cnt;
      logic [3:0]            pwr;
      logic [3:0]            sw;
      logic [3:0]            intf;
      logic                  cal_done;
      logic [15:0]           cal_cnt;
      logic [31:0]           path_time;
      logic                  aw_got;
      logic                  w_got;
      logic [7:0]            aw_addr;
      logic [31:0]           w_data;
      logic [3:0]            w_strb;
      logic                  awready;
      logic                  wready;
      logic                  bvalid;
      logic [1:0]            bresp;
      logic                  arready;
      logic                  rvalid;
      logic [31:0]           rdata;
      logic [1:0]            rresp;
   } tddseq_state_t;

   tddseq_state_t s_reg;
   tddseq_state_t s_next;

   logic [31:0] setup_cycles;

   // Register index inside a channel block, or NUM_PARAM when not in one
   function automatic logic [2:0] prm_index(input logic [7:0] a);
      logic [2:0] blk;
      blk = a[7:5];
      if (blk >= tddseq_pkg::CHAN_BLOCK_FIRST && blk <= 3'h4 && a[4:2] < 3'h5)
         return a[4:2];
      return 3'(tddseq_pkg::NUM_PARAM);
   endfunction

   function automatic logic [1:0] chan_index(input logic [7:0] a);
      return 2'(a[7:5] - tddseq_pkg::CHAN_BLOCK_FIRST);
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                         input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (strb[b])
            r[8*b +: 8] = d[8*b +: 8];
      end
      return r;
   endfunction

   always_comb begin
      setup_cycles = s_reg.retune ? 32'(RETUNE_SETUP_CYCLES)
                                  : 32'(tddseq_pkg::PLAIN_SETUP_CYCLES);
   end

   always_comb begin
      logic        en;
      logic        rise;
      logic        fall;
      logic        is_tx;
      logic [31:0] c;
      logic [33:0] sw_time;
      logic [31:0] fto;
      logic [2:0]  pi;
      logic [1:0]  ci;
      logic [31:0] rd;
      logic [1:0]  rr;
      en      = 1'b0;
      rise    = 1'b0;
      fall    = 1'b0;
      is_tx   = 1'b0;
      c       = '0;
      sw_time = '0;
      fto     = '0;
      pi      = '0;
      ci      = '0;
      rd      = '0;
      rr      = tddseq_pkg::RESP_OKAY;
      s_next  = s_reg;

      // Calibration window after reset, sequencers wait for it
      if (!s_reg.cal_done) begin
         if (s_reg.cal_cnt == 16'(tddseq_pkg::CAL_CYCLES - 1)) begin
            s_next.cal_done  = 1'b1;
            s_next.path_time = 32'(INTERNAL_PATH_CYCLES);
         end else begin
            s_next.cal_cnt = s_reg.cal_cnt + 16'h0001;
         end
      end

      // Per-channel sequencer, no sharing between channels
      for (int i = 0; i < tddseq_pkg::NUM_CHAN; i++) begin
         is_tx = (i < tddseq_pkg::NUM_TX);
         en    = chan_enable[i] & s_reg.cal_done;
         rise  = en & ~s_reg.en_d[i];
         fall  = ~en & s_reg.en_d[i];
         s_next.en_d[i] = en;
         if (rise || fall)
            c = '0;
         else if (s_reg.cnt[i] != tddseq_pkg::CNT_MAX)
            c = s_reg.cnt[i] + 32'h00000001;
         else
            c = s_reg.cnt[i];
         s_next.cnt[i] = c;
         if (rise)
            s_next.on_phase[i] = 1'b1;
         else if (fall)
            s_next.on_phase[i] = 1'b0;

         // Switch waits for the later of its own delay and analog setup
         sw_time = 34'(s_reg.prm[i][tddseq_pkg::PRM_POWER_UP]) + 34'(setup_cycles)
                   + 34'(tddseq_pkg::SWITCH_MARGIN_CYCLES);
         if (34'(s_reg.prm[i][tddseq_pkg::PRM_SWITCH]) > sw_time)
            sw_time = 34'(s_reg.prm[i][tddseq_pkg::PRM_SWITCH]);
         fto = is_tx ? s_reg.prm[i][tddseq_pkg::PRM_POWER_DOWN] : 32'h0;

         if (s_next.on_phase[i]) begin
            s_next.intf[i] = 1'b1;
            s_next.pwr[i]  = c >= s_reg.prm[i][tddseq_pkg::PRM_POWER_UP];
            s_next.sw[i]   = s_reg.ext_en[i] & (34'(c) >= sw_time);
         end else begin
            s_next.intf[i] = s_reg.intf[i] & (c < s_reg.prm[i][tddseq_pkg::PRM_IF_OFF]);
            s_next.pwr[i]  = s_reg.pwr[i] & (c < fto);
            s_next.sw[i]   = is_tx & s_reg.ext_en[i] & s_reg.sw[i] & (c < fto);
         end
      end

      // Write channel: address and data taken independently
      if (s_reg.awready && s_axi_awvalid) begin
         s_next.aw_got  = 1'b1;
         s_next.aw_addr = s_axi_awaddr;
      end
      if (s_reg.wready && s_axi_wvalid) begin
         s_next.w_got  = 1'b1;
         s_next.w_data = s_axi_wdata;
         s_next.w_strb = s_axi_wstrb;
      end
      if (s_reg.bvalid && s_axi_bready)
         s_next.bvalid = 1'b0;
      if (s_reg.aw_got && s_reg.w_got && !s_reg.bvalid) begin
         s_next.aw_got = 1'b0;
         s_next.w_got  = 1'b0;
         s_next.bvalid = 1'b1;
         s_next.bresp  = tddseq_pkg::RESP_OKAY;
         pi = prm_index(s_reg.aw_addr);
         ci = chan_index(s_reg.aw_addr);
         if (s_reg.aw_addr[1:0] != 2'h0) begin
            s_next.bresp = tddseq_pkg::RESP_SLVERR;
         end else if (s_reg.aw_addr == tddseq_pkg::CTRL_ADDR) begin
            if (s_reg.w_strb[0])
               s_next.ext_en = s_reg.w_data[tddseq_pkg::CTRL_EXT_EN_LSB +: 4];
            if (s_reg.w_strb[1])
               s_next.retune = s_reg.w_data[tddseq_pkg::CTRL_RETUNE_BIT];
         end else if (pi != 3'(tddseq_pkg::NUM_PARAM)) begin
            // Stored as written, out-of-range values included
            s_next.prm[ci][pi] = merge(s_reg.prm[ci][pi], s_reg.w_data, s_reg.w_strb);
         end else if (s_reg.aw_addr != tddseq_pkg::STATUS_ADDR
                      && s_reg.aw_addr != tddseq_pkg::SETUP_TIME_ADDR
                      && s_reg.aw_addr != tddseq_pkg::PATH_TIME_ADDR) begin
            s_next.bresp = tddseq_pkg::RESP_SLVERR;
         end
      end
      s_next.awready = ~s_next.aw_got & ~s_next.bvalid;
      s_next.wready  = ~s_next.w_got & ~s_next.bvalid;

      // Read channel
      if (s_reg.rvalid && s_axi_rready)
         s_next.rvalid = 1'b0;
      if (s_reg.arready && s_axi_arvalid) begin
         pi = prm_index(s_axi_araddr);
         ci = chan_index(s_axi_araddr);
         if (s_axi_araddr[1:0] != 2'h0) begin
            rr = tddseq_pkg::RESP_SLVERR;
         end else if (s_axi_araddr == tddseq_pkg::CTRL_ADDR) begin
            rd[tddseq_pkg::CTRL_EXT_EN_LSB +: 4] = s_reg.ext_en;
            rd[tddseq_pkg::CTRL_RETUNE_BIT]      = s_reg.retune;
         end else if (s_axi_araddr == tddseq_pkg::STATUS_ADDR) begin
            rd[tddseq_pkg::STAT_EN_LSB +: 4]  = s_reg.en_d;
            rd[tddseq_pkg::STAT_PWR_LSB +: 4] = s_reg.pwr;
            rd[tddseq_pkg::STAT_SW_LSB +: 4]  = s_reg.sw;
            rd[tddseq_pkg::STAT_IF_LSB +: 4]  = s_reg.intf;
            rd[tddseq_pkg::STAT_CAL_BIT]      = s_reg.cal_done;
         end else if (s_axi_araddr == tddseq_pkg::SETUP_TIME_ADDR) begin
            rd = setup_cycles;
         end else if (s_axi_araddr == tddseq_pkg::PATH_TIME_ADDR) begin
            rd = s_reg.path_time;
         end else if (pi != 3'(tddseq_pkg::NUM_PARAM)) begin
            rd = s_reg.prm[ci][pi];
         end else begin
            rr = tddseq_pkg::RESP_SLVERR;
         end
         s_next.rvalid = 1'b1;
         s_next.rdata  = rd;
         s_next.rresp  = rr;
      end
      s_next.arready = ~s_next.rvalid;
   end

   // Reset clears everything; delays all start at zero
   always_ff @(posedge aclk) begin
      if (!aresetn)
         s_reg <= '0;
      else
         s_reg <= s_next;
   end

   assign front_end_power  = s_reg.pwr;
   assign ext_switch_on    = s_reg.sw;
   assign interface_active = s_reg.intf;
   assign s_axi_awready    = s_reg.awready;
   assign s_axi_wready     = s_reg.wready;
   assign s_axi_bresp      = s_reg.bresp;
   assign s_axi_bvalid     = s_reg.bvalid;
   assign s_axi_arready    = s_reg.arready;
   assign s_axi_rdata      = s_reg.rdata;
   assign s_axi_rresp      = s_reg.rresp;
   assign s_axi_rvalid     = s_reg.rvalid;

endmodule // tddseq_top

/* bench/tddseq_monitor.sv */
module tddseq_monitor (
   input wire logic        aclk,              // Clock
   input wire logic        aresetn,           // Reset, low
   input wire logic [3:0]  chan_enable,       // Enables
   input wire logic [3:0]  front_end_power,   // Front end on
   input wire logic [3:0]  ext_switch_on,     // Switch or amplifier
   input wire logic [3:0]  interface_active,  // Interface on
   input wire logic        s_axi_awvalid,     // Aw valid
   input wire logic        s_axi_awready,     // Aw ready
   input wire logic        s_axi_wvalid,      // W valid
   input wire logic        s_axi_wready,      // W ready
   input wire logic        s_axi_bvalid,      // B valid
   input wire logic        s_axi_bready,      // B ready
   input wire logic        s_axi_arvalid,     // Ar valid
   input wire logic        s_axi_arready,     // Ar ready
   input wire logic [31:0] s_axi_rdata,       // Read data
   input wire logic        s_axi_rvalid,      // R valid
   input wire logic        s_axi_rready       // R ready
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   logic [6:0] warm_reg;
   // Enables are ignored during calibration, so skip that span
   always_ff @(posedge aclk) begin
      if (!aresetn) warm_reg <= 7'h00;
      else if (warm_reg != 7'h7F) warm_reg <= warm_reg + 7'h01;
   end
   for (genvar i = 0; i < 4; i++) begin : g_ch
      a_rise_opens_if: assert property (warm_reg > 7'h50 && $rose(chan_enable[i])
         |-> ##[1:2] interface_active[i]) else $error("interface not opened");
      a_switch_powered: assert property (ext_switch_on[i] |-> front_end_power[i])
         else $error("switch on without front end power");
      a_setup_first: assert property ($rose(front_end_power[i])
         |-> !ext_switch_on[i] [*8]) else $error("switch too soon after power up");
   end
   for (genvar i = 2; i < 4; i++) begin : g_rx
      a_rx_fall_off: assert property (warm_reg > 7'h50 && $fell(chan_enable[i])
         |-> ##[1:2] !front_end_power[i] && !ext_switch_on[i]) else $error("rx not off");
   end
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
      else $error("read answer late");
   a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##2 s_axi_bvalid) else $error("write answer late");
   a_aw_refused: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
      else $error("second write address accepted");
   a_b_done: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write response repeated");
   a_r_done: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
      else $error("read response repeated");
   c_switch: cover property (ext_switch_on[0]);
   c_write: cover property (s_axi_bvalid && s_axi_bready);
   c_if_off: cover property ($fell(interface_active[0]));
endmodule // tddseq_monitor

bind tddseq_top tddseq_monitor mon_u (.aclk(aclk), .aresetn(aresetn), .chan_enable(chan_enable),
   .front_end_power(front_end_power), .ext_switch_on(ext_switch_on),
   .interface_active(interface_active), .s_axi_awvalid(s_axi_awvalid),
   .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready));

/* bench/tddseq_baseband.sv */
module tddseq_baseband (
   input wire logic       aclk,         // Clock
   output logic     [3:0] chan_enable   // Enables to the sequencer
);
   timeunit 1ns;
   timeprecision 1ps;
   initial chan_enable = 4'h0;
   // Edges mark burst start and end at the data port
   task automatic drive(input int ch, input logic lvl);
      @(posedge aclk);
      chan_enable[ch] <= lvl;
   endtask
endmodule // tddseq_baseband

/* bench/tddseq_top_bench.sv */
module tddseq_top_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready;
   logic [3:0]  chan_enable, pwr, sw, intf, wstrb;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, rdata, d;
   logic [1:0]  bresp, rresp, r;
   int          err_count, tests_run;
   int          t[3];
   initial aclk = 1'b0;
   always #2 aclk = ~aclk;
   tddseq_baseband bb_u (.aclk(aclk), .chan_enable(chan_enable));
   tddseq_top #(.RETUNE_SETUP_CYCLES(300)) dut_u (.aclk(aclk), .aresetn(aresetn),
      .chan_enable(chan_enable), .front_end_power(pwr), .ext_switch_on(sw),
      .interface_active(intf), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch at %0t: read %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chkn(input int got, input int exp);
      tests_run++;
      if (got != exp) begin
         err_count++;
         $display("mismatch at %0t: cycles %0d expected %0d", $time, got, exp);
      end
   endtask
   // Waits for the answer however long; only the watchdog ends a hang
   task automatic axw(input logic [7:0] a, input logic [31:0] v);
      bit dn;
      dn = 1'b0;
      @(posedge aclk);
      awaddr <= a; wdata <= v; wstrb <= 4'hF; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
      while (!dn) begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (bvalid) begin
            r = bresp; bready <= 1'b0; dn = 1'b1;
         end
      end
   endtask
   task automatic axr(input logic [7:0] a);
      bit dn;
      dn = 1'b0;
      @(posedge aclk);
      araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
      while (!dn) begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
         if (rvalid) begin
            d = rdata; r = rresp; rready <= 1'b0; dn = 1'b1;
         end
      end
   endtask
   task automatic prm(input int ch, input logic [31:0] pu, sws, hd, pd);
      logic [7:0] b;
      b = 8'(32 + 32 * ch);
      axw(b, pu); axw(b + 8'h04, sws); axw(b + 8'h0C, hd); axw(b + 8'h10, pd);
   endtask
   // First cycle each output reaches the new level, 0 if never
   task automatic edge_run(input int ch, input logic lvl, input int lim);
      t = '{0, 0, 0};
      bb_u.drive(ch, lvl);
      for (int n = 1; n <= lim; n++) begin
         @(posedge aclk);
         #1;
         if (t[0] == 0 && pwr[ch] === lvl) t[0] = n;
         if (t[1] == 0 && sw[ch] === lvl) t[1] = n;
         if (t[2] == 0 && intf[ch] === lvl) t[2] = n;
      end
   endtask
   task automatic exp3(input int a, input int b, input int c);
      chkn(t[0], a); chkn(t[1], b); chkn(t[2], c);
   endtask
   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   initial begin
      #100000;
      err_count++;
      $display("mismatch at %0t: watchdog expired", $time);
      report_and_stop;
   end
   initial begin
      err_count = 0; tests_run = 0; aresetn = 1'b0; awaddr = 8'h00; araddr = 8'h00;
      wdata = 32'h0; wstrb = 4'h0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0;
      arvalid = 1'b0; rready = 1'b0;
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      // Wait out calibration before touching the enables
      repeat (70) @(posedge aclk);
      axr(8'h04); chk(d & 32'h00010000, 32'h00010000);
      axr(8'h0C); chk(d, 32'h00000064);
      axr(8'h08); chk(d, 32'h000007D0);
      axr(8'h14); chk({30'h0, r}, 32'h00000002); chk(d, 32'h00000000);
      axw(8'h28, 32'hFFFFFFFF); axr(8'h28); chk(d, 32'hFFFFFFFF);
      axw(8'h28, 32'h00000000);
      chk({30'h0, r}, 32'h00000000);
      axw(8'h14, 32'h00000001); chk({30'h0, r}, 32'h00000002);
      $display("test registers done");
      axw(8'h00, 32'h00000005);
      prm(0, 32'h2, 32'h0, 32'h3, 32'h5);
      edge_run(0, 1'b1, 2100); exp3(3, 2019, 1);
      chk({28'h0, pwr}, 32'h00000001);
      edge_run(0, 1'b0, 10); exp3(6, 6, 4);
      prm(2, 32'h9C4, 32'h0, 32'h4, 32'h9);
      edge_run(2, 1'b1, 4600); exp3(2501, 4517, 1);
      edge_run(2, 1'b0, 12); exp3(1, 1, 5);
      $display("test tx1 rx1 done");
      prm(1, 32'h0, 32'hBB8, 32'h0, 32'h64);
      edge_run(1, 1'b1, 3100); exp3(1, 0, 1);
      edge_run(1, 1'b0, 120); exp3(101, 1, 1);
      axw(8'h00, 32'h0000010F); axr(8'h08); chk(d, 32'h0000012C);
      edge_run(1, 1'b1, 3100); exp3(1, 3001, 1);
      edge_run(1, 1'b0, 120); exp3(101, 101, 1);
      prm(3, 32'h0, 32'h0, 32'h0, 32'h0);
      edge_run(3, 1'b1, 400); exp3(1, 317, 1);
      edge_run(3, 1'b0, 5); exp3(1, 1, 1);
      $display("test tx2 rx2 done");
      report_and_stop;
   end
endmodule // tddseq_top_bench
